// File: hw/cpu_regset.sv
// Processor register set: general, segment, pointer and status registers
//
// Operation
// - Eight 16-bit general registers; four also split into byte halves.
// - Base word, frame base, source and destination index form operand offsets.
// - Push and pop use stack pointer in stack segment, no override.
// - Four 16-bit segment registers for code, two data, and stack.
// - Instruction pointer holds offset of next sequential instruction.
// - Status bits 0,2,4,6,7,11 record results; bits 8,9,10 control.
// - Overflow bit 11 set when signed result does not fit.
// - Direction bit 10 set decrements string indices, clear increments.
// - Interrupt enable bit 9 gates maskable interrupts.
// - Trace bit 8 raises trace interrupt per instruction; cleared after push.
// - Sign bit 7 equals result most significant bit.
// - Zero bit 6 set when result is zero.
// - Nibble carry bit 4 on carry or borrow of low four bits.
// - Parity bit 2 set when low result byte has even ones.
// - Carry bit 0 on carry or borrow of most significant bit.
// - Flags may be set, cleared, unchanged or undefined after an instruction.
// - Physical address is segment shifted left four plus offset, 20 bits.
// - Memory address pairs one segment register with a 16-bit offset.
// - Port space addressed by 8-bit immediate or port data word.
// - Immediate port address is zero-extended, upper byte low.
// - Peripheral registers are reached as port operands or as memory operands.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module cpu_regset (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire cpu_regset_pkg::gpr_wr_s gpr_wr,
   input wire logic seg_wr_en,
   input wire cpu_regset_pkg::seg_e seg_wr_sel,
   input wire logic [15:0] seg_wr_data,
   input wire cpu_regset_pkg::alu_req_s alu_req,
   output logic [15:0] alu_result,
   input wire logic psw_wr_en,
   input wire logic [15:0] psw_wr_mask,
   input wire logic [15:0] psw_wr_data,
   output logic [15:0] psw,
   input wire cpu_regset_pkg::agen_req_s agen_req,
   output logic [19:0] mem_addr,
   output logic mem_addr_valid,
   input wire cpu_regset_pkg::io_req_s io_req,
   output logic [15:0] io_addr,
   output logic io_addr_valid,
   input wire cpu_regset_pkg::str_req_s str_req,
   input wire logic ip_load,
   input wire logic [15:0] ip_load_val,
   input wire logic ip_adv,
   input wire logic [3:0] ip_adv_len,
   output logic [15:0] next_ip_offset,
   input wire logic irq_req,
   output logic irq_take,
   input wire logic instr_done,
   input wire logic int_entry,
   output logic trace_req
);

   logic [15:0] gpr_q [8];
   logic [15:0] seg_q [4];
   logic [15:0] ip_q;
   logic [15:0] psw_q;
   logic [15:0] psw_d;
   logic trace_pend_q;
   logic [15:0] rdata_q;
   logic [15:0] result_q;
   logic [19:0] mem_addr_q;
   logic mem_valid_q;
   logic [15:0] io_addr_q;
   logic io_valid_q;

   logic [15:0] op_a;
   logic [15:0] op_b;
   logic [16:0] full;
   logic [15:0] res;
   logic a_msb;
   logic b_msb;
   logic r_msb;
   logic carry;
   logic ovf;
   logic [15:0] flags_new;

   logic [15:0] base_v;
   logic [15:0] idx_v;
   logic [15:0] agen_off;
   logic [1:0] agen_seg;
   logic [15:0] sp_next;

   logic [15:0] str_delta;
   logic gpr_sw_wr;
   logic seg_sw_wr;

   function automatic logic [19:0] phys_addr(input logic [15:0] seg, input logic [15:0] off);
      phys_addr = {seg, 4'h0} + {4'h0, off};
   endfunction

   function automatic logic [15:0] step_amt(input logic word, input logic down);
      logic [15:0] mag;
      mag = word ? cpu_regset_pkg::STEP_WORD : cpu_regset_pkg::STEP_BYTE;
      step_amt = down ? (16'h0000 - mag) : mag;
   endfunction

   function automatic logic [15:0] read_mux(input logic [3:0] idx,
                                            input logic [15:0] g [8],
                                            input logic [15:0] s [4],
                                            input logic [15:0] ip,
                                            input logic [15:0] f);
      logic [15:0] v;
      v = 16'h0000;
      if (idx <= cpu_regset_pkg::REG_DST) begin
         v = g[idx[2:0]];
      end else if (idx <= cpu_regset_pkg::REG_DS) begin
         v = s[idx[1:0]];
      end else if (idx == cpu_regset_pkg::REG_IP) begin
         v = ip;
      end else if (idx == cpu_regset_pkg::REG_PSW) begin
         v = f;
      end
      read_mux = v;
   endfunction

   assign gpr_sw_wr = reg_wr && (reg_addr <= cpu_regset_pkg::REG_DST);
   assign seg_sw_wr = reg_wr && (reg_addr >= cpu_regset_pkg::REG_ES)
                      && (reg_addr <= cpu_regset_pkg::REG_DS);

   // Flag generation. Byte operations are zero-extended so the
   // byte carry or borrow lands in bit 8 of the wide sum.
   always_comb begin
      op_a = alu_req.word ? alu_req.a : {8'h00, alu_req.a[7:0]};
      op_b = alu_req.word ? alu_req.b : {8'h00, alu_req.b[7:0]};
      case (alu_req.op)
         cpu_regset_pkg::ALU_ADD: begin
            full = {1'b0, op_a} + {1'b0, op_b} + {16'h0000, alu_req.cin};
         end
         cpu_regset_pkg::ALU_SUB: begin
            full = {1'b0, op_a} - {1'b0, op_b} - {16'h0000, alu_req.cin};
         end
         default: begin
            full = {1'b0, op_b};
         end
      endcase
      res = alu_req.word ? full[15:0] : {8'h00, full[7:0]};
      a_msb = alu_req.word ? op_a[15] : op_a[7];
      b_msb = alu_req.word ? op_b[15] : op_b[7];
      r_msb = alu_req.word ? res[15] : res[7];
      carry = alu_req.word ? full[16] : full[8];
      case (alu_req.op)
         cpu_regset_pkg::ALU_ADD: begin
            ovf = (a_msb == b_msb) && (r_msb != a_msb);
         end
         cpu_regset_pkg::ALU_SUB: begin
            ovf = (a_msb != b_msb) && (r_msb != a_msb);
         end
         default: begin
            ovf = 1'b0;
         end
      endcase
      flags_new = 16'h0000;
      flags_new[cpu_regset_pkg::FL_OVF] = ovf;
      flags_new[cpu_regset_pkg::FL_SIGN] = r_msb;
      flags_new[cpu_regset_pkg::FL_ZERO] = (res == 16'h0000);
      // Logic results leave nibble carry at zero; its value is meaningless there
      flags_new[cpu_regset_pkg::FL_NIBBLE] = (alu_req.op != cpu_regset_pkg::ALU_LOGIC)
                                             && (op_a[4] ^ op_b[4] ^ full[4]);
      flags_new[cpu_regset_pkg::FL_PARITY] = ~^res[7:0];
      flags_new[cpu_regset_pkg::FL_CARRY] = (alu_req.op != cpu_regset_pkg::ALU_LOGIC)
                                            && carry;
   end

   // Only result bits may be touched by an instruction result
   always_comb begin
      psw_d = psw_q;
      if (alu_req.en) begin
         psw_d = (psw_d & ~(alu_req.fmask & cpu_regset_pkg::PSW_ARITH))
                 | (flags_new & alu_req.fmask & cpu_regset_pkg::PSW_ARITH);
      end
      if (psw_wr_en) begin
         psw_d = (psw_d & ~psw_wr_mask) | (psw_wr_data & psw_wr_mask);
      end
      if (reg_wr && (reg_addr == cpu_regset_pkg::REG_PSW)) begin
         psw_d = reg_wdata;
      end
      if (int_entry) begin
         psw_d[cpu_regset_pkg::FL_TRACE] = 1'b0;
      end
      psw_d = (psw_d & cpu_regset_pkg::PSW_WR_MASK) | cpu_regset_pkg::PSW_FIXED;
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         psw_q <= cpu_regset_pkg::PSW_RST;
      end else if (clk_en) begin
         psw_q <= psw_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         result_q <= cpu_regset_pkg::WORD_RST;
      end else if (clk_en && alu_req.en) begin
         result_q <= res;
      end
   end

   // Trace request set by a finished instruction wins over entry clear
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         trace_pend_q <= 1'b0;
      end else if (clk_en) begin
         if (instr_done && psw_q[cpu_regset_pkg::FL_TRACE]) begin
            trace_pend_q <= 1'b1;
         end else if (int_entry) begin
            trace_pend_q <= 1'b0;
         end
      end
   end

   assign irq_take = irq_req && psw_q[cpu_regset_pkg::FL_IEN];

   // Offset formation; stack requests ignore the segment field entirely
   always_comb begin
      case (agen_req.base)
         cpu_regset_pkg::BASE_BW: base_v = gpr_q[cpu_regset_pkg::REG_BASE[2:0]];
         cpu_regset_pkg::BASE_BP: base_v = gpr_q[cpu_regset_pkg::REG_BP[2:0]];
         default: base_v = 16'h0000;
      endcase
      case (agen_req.index)
         cpu_regset_pkg::INDEX_SRC: idx_v = gpr_q[cpu_regset_pkg::REG_SRC[2:0]];
         cpu_regset_pkg::INDEX_DST: idx_v = gpr_q[cpu_regset_pkg::REG_DST[2:0]];
         default: idx_v = 16'h0000;
      endcase
      sp_next = gpr_q[cpu_regset_pkg::REG_SP[2:0]];
      case (agen_req.stk)
         cpu_regset_pkg::STK_PUSH: begin
            sp_next = gpr_q[cpu_regset_pkg::REG_SP[2:0]] - cpu_regset_pkg::STEP_WORD;
            agen_off = sp_next;
            agen_seg = cpu_regset_pkg::SEG_SS;
         end
         cpu_regset_pkg::STK_POP: begin
            sp_next = gpr_q[cpu_regset_pkg::REG_SP[2:0]] + cpu_regset_pkg::STEP_WORD;
            agen_off = gpr_q[cpu_regset_pkg::REG_SP[2:0]];
            agen_seg = cpu_regset_pkg::SEG_SS;
         end
         default: begin
            agen_off = base_v + idx_v + agen_req.disp;
            agen_seg = agen_req.seg;
         end
      endcase
   end

   assign str_delta = step_amt(str_req.word, psw_q[cpu_regset_pkg::FL_DIR]);

   // General registers; a port write lands last and so wins the cycle
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         for (int i = 0; i < 8; i++) begin
            gpr_q[i] <= cpu_regset_pkg::WORD_RST;
         end
      end else if (clk_en) begin
         if (str_req.en && str_req.step_src) begin
            gpr_q[cpu_regset_pkg::REG_SRC[2:0]] <=
               gpr_q[cpu_regset_pkg::REG_SRC[2:0]] + str_delta;
         end
         if (str_req.en && str_req.step_dst) begin
            gpr_q[cpu_regset_pkg::REG_DST[2:0]] <=
               gpr_q[cpu_regset_pkg::REG_DST[2:0]] + str_delta;
         end
         if (agen_req.en && (agen_req.stk != cpu_regset_pkg::STK_NONE)) begin
            gpr_q[cpu_regset_pkg::REG_SP[2:0]] <= sp_next;
         end
         if (gpr_wr.en && !gpr_wr.byte_mode) begin
            gpr_q[gpr_wr.sel] <= gpr_wr.data;
         end
         if (gpr_wr.en && gpr_wr.byte_mode && !gpr_wr.sel[2]) begin
            gpr_q[{1'b0, gpr_wr.sel[1:0]}][7:0] <= gpr_wr.data[7:0];
         end
         if (gpr_wr.en && gpr_wr.byte_mode && gpr_wr.sel[2]) begin
            gpr_q[{1'b0, gpr_wr.sel[1:0]}][15:8] <= gpr_wr.data[7:0];
         end
         if (gpr_sw_wr) begin
            gpr_q[reg_addr[2:0]] <= reg_wdata;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         for (int i = 0; i < 4; i++) begin
            seg_q[i] <= cpu_regset_pkg::WORD_RST;
         end
      end else if (clk_en) begin
         if (seg_wr_en) begin
            seg_q[seg_wr_sel] <= seg_wr_data;
         end
         if (seg_sw_wr) begin
            seg_q[reg_addr[1:0]] <= reg_wdata;
         end
      end
   end

   // A load takes priority over sequential advance
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ip_q <= cpu_regset_pkg::WORD_RST;
      end else if (clk_en) begin
         if (reg_wr && (reg_addr == cpu_regset_pkg::REG_IP)) begin
            ip_q <= reg_wdata;
         end else if (ip_load) begin
            ip_q <= ip_load_val;
         end else if (ip_adv) begin
            ip_q <= ip_q + {12'h000, ip_adv_len};
         end
      end
   end

   // Memory address; memory-mapped peripheral registers are reached through this path, port-mapped ones through the port address below
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         mem_addr_q <= 20'h00000;
         mem_valid_q <= 1'b0;
      end else if (clk_en) begin
         mem_valid_q <= agen_req.en;
         if (agen_req.en) begin
            mem_addr_q <= phys_addr(seg_q[agen_seg], agen_off);
         end
      end
   end

   // Reserved ports are not screened here; keeping off them is up to software
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         io_addr_q <= cpu_regset_pkg::WORD_RST;
         io_valid_q <= 1'b0;
      end else if (clk_en) begin
         io_valid_q <= io_req.en;
         if (io_req.en && io_req.imm_mode) begin
            io_addr_q <= {8'h00, io_req.imm};
         end else if (io_req.en) begin
            io_addr_q <= gpr_q[cpu_regset_pkg::REG_PORT[2:0]];
         end
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rdata_q <= cpu_regset_pkg::WORD_RST;
      end else if (clk_en) begin
         rdata_q <= reg_rd ? read_mux(reg_addr, gpr_q, seg_q, ip_q, psw_q) : 16'h0000;
      end
   end

   assign reg_rdata = rdata_q;
   assign alu_result = result_q;
   assign psw = psw_q;
   assign mem_addr = mem_addr_q;
   assign mem_addr_valid = mem_valid_q;
   assign io_addr = io_addr_q;
   assign io_addr_valid = io_valid_q;
   assign next_ip_offset = ip_q;
   assign trace_req = trace_pend_q;

endmodule

// File: hw/cpu_regset_pkg.sv
// Shared constants, enumerations and carriers for the processor register set
package cpu_regset_pkg;
   // Register port indices
   localparam logic [3:0] REG_ACC = 4'h0;
   localparam logic [3:0] REG_CNT = 4'h1;
   localparam logic [3:0] REG_PORT = 4'h2;
   localparam logic [3:0] REG_BASE = 4'h3;
   localparam logic [3:0] REG_SP = 4'h4;
   localparam logic [3:0] REG_BP = 4'h5;
   localparam logic [3:0] REG_SRC = 4'h6;
   localparam logic [3:0] REG_DST = 4'h7;
   localparam logic [3:0] REG_ES = 4'h8;
   localparam logic [3:0] REG_CS = 4'h9;
   localparam logic [3:0] REG_SS = 4'ha;
   localparam logic [3:0] REG_DS = 4'hb;
   localparam logic [3:0] REG_IP = 4'hc;
   localparam logic [3:0] REG_PSW = 4'hd;

   // Status word bit positions
   localparam int FL_CARRY = 0;
   localparam int FL_PARITY = 2;
   localparam int FL_NIBBLE = 4;
   localparam int FL_ZERO = 6;
   localparam int FL_SIGN = 7;
   localparam int FL_TRACE = 8;
   localparam int FL_IEN = 9;
   localparam int FL_DIR = 10;
   localparam int FL_OVF = 11;

   localparam logic [15:0] PSW_WR_MASK = 16'h0fd5;
   localparam logic [15:0] PSW_ARITH = 16'h08d5;
   localparam logic [15:0] PSW_FIXED = 16'hf002;
   localparam logic [15:0] PSW_RST = 16'hf002;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam logic [15:0] STEP_BYTE = 16'h0001;

   typedef enum logic [1:0] {ALU_ADD = 2'b00, ALU_SUB = 2'b01, ALU_LOGIC = 2'b10} alu_op_e;
   typedef enum logic [1:0] {SEG_ES = 2'b00, SEG_CS = 2'b01, SEG_SS = 2'b10, SEG_DS = 2'b11} seg_e;
   typedef enum logic [1:0] {BASE_NONE = 2'b00, BASE_BW = 2'b01, BASE_BP = 2'b10} base_e;
   typedef enum logic [1:0] {INDEX_NONE = 2'b00, INDEX_SRC = 2'b01, INDEX_DST = 2'b10} index_e;
   typedef enum logic [1:0] {STK_NONE = 2'b00, STK_PUSH = 2'b01, STK_POP = 2'b10} stack_e;

   typedef struct packed {
      logic en;
      logic byte_mode;
      logic [2:0] sel;
      logic [15:0] data;
   } gpr_wr_s;

   typedef struct packed {
      logic en;
      alu_op_e op;
      logic word;
      logic cin;
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] fmask;
   } alu_req_s;

   typedef struct packed {
      logic en;
      seg_e seg;
      base_e base;
      index_e index;
      logic [15:0] disp;
      stack_e stk;
   } agen_req_s;

   typedef struct packed {
      logic en;
      logic imm_mode;
      logic [7:0] imm;
   } io_req_s;

   typedef struct packed {
      logic en;
      logic word;
      logic step_src;
      logic step_dst;
   } str_req_s;
endpackage

// File: test/cpu_register_set_and_addressing_bench.sv
// Self-checking bench for the processor register set
`timescale 1ns/10ps
module cpu_register_set_and_addressing_bench;
   logic core_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0, ip_adv_len = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, seg_wr_data = 16'h0000, ip_load_val = 16'h0000;
   logic [15:0] psw_wr_mask = 16'h0000, psw_wr_data = 16'h0000;
   logic seg_wr_en = 1'b0, psw_wr_en = 1'b0, ip_load = 1'b0, ip_adv = 1'b0;
   logic irq_req = 1'b0, instr_done = 1'b0, int_entry = 1'b0;
   cpu_regset_pkg::seg_e seg_wr_sel = cpu_regset_pkg::SEG_ES;
   cpu_regset_pkg::gpr_wr_s gpr_wr = '0;
   cpu_regset_pkg::alu_req_s alu_req = '0;
   cpu_regset_pkg::agen_req_s agen_req = '0;
   cpu_regset_pkg::io_req_s io_req = '0;
   cpu_regset_pkg::str_req_s str_req = '0;
   logic [15:0] reg_rdata, alu_result, psw, io_addr, next_ip_offset, last_io;
   logic [19:0] mem_addr, last_mem;
   logic [7:0] reserved_hits;
   logic mem_addr_valid, io_addr_valid, irq_take, trace_req;
   int miscompares = 0, samples_checked = 0, cycles = 0;
   cpu_regset i_cpu_regset (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .gpr_wr(gpr_wr), .seg_wr_en(seg_wr_en), .seg_wr_sel(seg_wr_sel),
      .seg_wr_data(seg_wr_data), .alu_req(alu_req), .alu_result(alu_result),
      .psw_wr_en(psw_wr_en), .psw_wr_mask(psw_wr_mask), .psw_wr_data(psw_wr_data), .psw(psw),
      .agen_req(agen_req), .mem_addr(mem_addr), .mem_addr_valid(mem_addr_valid),
      .io_req(io_req), .io_addr(io_addr), .io_addr_valid(io_addr_valid), .str_req(str_req),
      .ip_load(ip_load), .ip_load_val(ip_load_val), .ip_adv(ip_adv), .ip_adv_len(ip_adv_len),
      .next_ip_offset(next_ip_offset), .irq_req(irq_req), .irq_take(irq_take),
      .instr_done(instr_done), .int_entry(int_entry), .trace_req(trace_req));
   mem_io_partner i_mem_io_partner (.core_clk(core_clk), .mem_addr(mem_addr),
      .mem_addr_valid(mem_addr_valid), .io_addr(io_addr), .io_addr_valid(io_addr_valid),
      .last_mem(last_mem), .last_io(last_io), .reserved_hits(reserved_hits));
   always #5 core_clk = ~core_clk;
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         give_verdict;
      end
   end
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk({4'h0, reg_rdata}, {4'h0, e});
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic gpr(input logic [20:0] w);
      @(posedge core_clk);
      gpr_wr <= w;
      @(posedge core_clk);
      gpr_wr <= '0;
   endtask
   task automatic seg(input cpu_regset_pkg::seg_e s, input logic [15:0] d);
      @(posedge core_clk);
      seg_wr_en <= 1'b1;
      seg_wr_sel <= s;
      seg_wr_data <= d;
      @(posedge core_clk);
      seg_wr_en <= 1'b0;
   endtask
   task automatic pswr(input logic [15:0] m, input logic [15:0] d);
      @(posedge core_clk);
      psw_wr_en <= 1'b1;
      psw_wr_mask <= m;
      psw_wr_data <= d;
      @(posedge core_clk);
      psw_wr_en <= 1'b0;
   endtask
   task automatic agen(input logic [24:0] r, input logic [19:0] e);
      @(posedge core_clk);
      agen_req <= r;
      @(posedge core_clk);
      agen_req <= '0;
      #1 chk(mem_addr, e);
      // Far side latches one edge later
      @(posedge core_clk);
      #1 chk(last_mem, e);
   endtask
   task automatic alu(input logic [52:0] r, input logic [15:0] er, input logic [15:0] ep);
      @(posedge core_clk);
      alu_req <= r;
      @(posedge core_clk);
      alu_req <= '0;
      #1 chk({4'h0, alu_result}, {4'h0, er});
      chk({4'h0, psw}, {4'h0, ep});
   endtask
   task automatic io(input logic [9:0] r, input logic [15:0] e);
      @(posedge core_clk);
      io_req <= r;
      @(posedge core_clk);
      io_req <= '0;
      @(posedge core_clk);
      #1 chk({4'h0, last_io}, {4'h0, e});
   endtask
   task automatic strs(input logic [3:0] r);
      @(posedge core_clk);
      str_req <= r;
      @(posedge core_clk);
      str_req <= '0;
   endtask
   task automatic t_reset;
      rd(cpu_regset_pkg::REG_PSW, 16'hf002);
      rd(cpu_regset_pkg::REG_IP, 16'h0000);
      wr(4'hf, 16'hffff);
      rd(4'hf, 16'h0000);
   endtask
   task automatic t_gpr;
      gpr({1'b1, 1'b0, 3'h0, 16'h1234});
      gpr({1'b1, 1'b1, 3'h4, 16'h00ab});
      rd(cpu_regset_pkg::REG_ACC, 16'hab34);
      gpr({1'b1, 1'b1, 3'h0, 16'h00cd});
      rd(cpu_regset_pkg::REG_ACC, 16'habcd);
      // Read data must fall back to zero once the strobe has gone
      @(posedge core_clk);
      #1 chk({4'h0, reg_rdata}, 20'h00000);
   endtask
   task automatic t_addr;
      seg(cpu_regset_pkg::SEG_DS, 16'h12a4);
      agen({1'b1, cpu_regset_pkg::SEG_DS, 4'h0, 16'h0022, 2'h0}, 20'h12a62);
      gpr({1'b1, 1'b0, 3'h3, 16'h0010});
      gpr({1'b1, 1'b0, 3'h6, 16'h0001});
      gpr({1'b1, 1'b0, 3'h5, 16'h0100});
      gpr({1'b1, 1'b0, 3'h7, 16'h0003});
      seg(cpu_regset_pkg::SEG_ES, 16'h0001);
      agen({1'b1, cpu_regset_pkg::SEG_ES, 4'h5, 16'h0002, 2'h0}, 20'h00023);
      agen({1'b1, cpu_regset_pkg::SEG_CS, 4'ha, 16'h0000, 2'h0}, 20'h00103);
      seg(cpu_regset_pkg::SEG_SS, 16'h1000);
      wr(cpu_regset_pkg::REG_SP, 16'h0100);
      // Data segment is offered on purpose; the stack must ignore it
      agen({1'b1, cpu_regset_pkg::SEG_DS, 4'h0, 16'h0000, 2'h1}, 20'h100fe);
      rd(cpu_regset_pkg::REG_SP, 16'h00fe);
      agen({1'b1, cpu_regset_pkg::SEG_DS, 4'h0, 16'h0000, 2'h2}, 20'h100fe);
      rd(cpu_regset_pkg::REG_SP, 16'h0100);
   endtask
   task automatic t_io;
      io({1'b1, 1'b1, 8'hf8}, 16'h00f8);
      chk({12'h000, reserved_hits}, 20'h00001);
      gpr({1'b1, 1'b0, 3'h2, 16'h1234});
      io({1'b1, 1'b0, 8'hf8}, 16'h1234);
   endtask
   task automatic t_alu;
      alu({1'b1, cpu_regset_pkg::ALU_ADD, 2'h2, 16'h7fff, 16'h0001, 16'hffff},
         16'h8000, 16'hf896);
      alu({1'b1, cpu_regset_pkg::ALU_SUB, 2'h2, 16'h0000, 16'h0001, 16'hffff},
         16'hffff, 16'hf097);
      alu({1'b1, cpu_regset_pkg::ALU_ADD, 2'h0, 16'h0080, 16'h0080, 16'hffff},
         16'h0000, 16'hf847);
      alu({1'b1, cpu_regset_pkg::ALU_LOGIC, 2'h2, 16'h0000, 16'h0000, 16'hffff},
         16'h0000, 16'hf046);
      wr(cpu_regset_pkg::REG_PSW, 16'hffff);
      rd(cpu_regset_pkg::REG_PSW, 16'hffd7);
      // Empty flag mask: carry in counts, status word stays as it was
      alu({1'b1, cpu_regset_pkg::ALU_ADD, 2'h3, 16'h0001, 16'h0001, 16'h0000},
         16'h0003, 16'hffd7);
   endtask
   task automatic t_str;
      pswr(16'h0700, 16'h0000);
      gpr({1'b1, 1'b0, 3'h6, 16'h0010});
      strs(4'hf);
      rd(cpu_regset_pkg::REG_SRC, 16'h0012);
      pswr(16'h0400, 16'h0400);
      strs(4'hb);
      rd(cpu_regset_pkg::REG_SRC, 16'h0011);
   endtask
   task automatic t_ip_irq;
      @(posedge core_clk);
      ip_load <= 1'b1;
      ip_load_val <= 16'h0100;
      irq_req <= 1'b1;
      @(posedge core_clk);
      ip_load <= 1'b0;
      ip_adv <= 1'b1;
      ip_adv_len <= 4'h3;
      @(posedge core_clk);
      ip_adv <= 1'b0;
      #1 chk({4'h0, next_ip_offset}, 20'h00103);
      chk({19'h0, irq_take}, 20'h00000);
      pswr(16'h0200, 16'h0200);
      #1 chk({19'h0, irq_take}, 20'h00001);
      @(posedge core_clk);
      irq_req <= 1'b0;
   endtask
   task automatic t_trace;
      pswr(16'h0100, 16'h0100);
      @(posedge core_clk);
      instr_done <= 1'b1;
      @(posedge core_clk);
      instr_done <= 1'b0;
      #1 chk({19'h0, trace_req}, 20'h00001);
      @(posedge core_clk);
      int_entry <= 1'b1;
      @(posedge core_clk);
      int_entry <= 1'b0;
      #1 chk({18'h0, trace_req, psw[8]}, 20'h00000);
   endtask
   task automatic t_hold;
      // A write while the enable is low must leave the accumulator alone
      @(posedge core_clk);
      clk_en <= 1'b0;
      wr(cpu_regset_pkg::REG_ACC, 16'h5555);
      clk_en <= 1'b1;
      rd(cpu_regset_pkg::REG_ACC, 16'habcd);
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset;
      t_gpr;
      t_addr;
      t_io;
      t_alu;
      t_str;
      t_ip_irq;
      t_trace;
      t_hold;
      give_verdict;
   end
endmodule

// File: test/cpu_regset_chk.sv
// Port assertions for the processor register set
`timescale 1ns/10ps
module cpu_regset_chk (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic reg_wr,
   input wire logic psw_wr_en,
   input wire logic [15:0] psw,
   input wire logic irq_req,
   input wire logic irq_take,
   input wire logic instr_done,
   input wire logic int_entry,
   input wire logic trace_req,
   input wire cpu_regset_pkg::io_req_s io_req,
   input wire logic [15:0] io_addr,
   input wire logic io_addr_valid,
   input wire cpu_regset_pkg::agen_req_s agen_req,
   input wire logic mem_addr_valid,
   input wire cpu_regset_pkg::alu_req_s alu_req,
   input wire logic [15:0] alu_result
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   chk_irq_gate_open: assert property (irq_take == (irq_req & psw[9]))
      else $error("interrupt gate mismatch");
   chk_fixed_psw_bits: assert property ((psw & 16'hf02a) == 16'hf002)
      else $error("reserved status bits moved");
   chk_io_zero_ext: assert property (clk_en && io_req.en && io_req.imm_mode
      |=> io_addr_valid && io_addr == {8'h00, $past(io_req.imm)})
      else $error("immediate port not zero extended");
   chk_agen_valid: assert property (clk_en && agen_req.en |=> mem_addr_valid)
      else $error("address valid missing");
   chk_agen_idle: assert property (clk_en && !agen_req.en |=> !mem_addr_valid)
      else $error("address valid without request");
   chk_trace_raise: assert property (clk_en && instr_done && psw[8] |=> trace_req)
      else $error("trace request not raised");
   chk_trace_clear: assert property (clk_en && int_entry && !instr_done && !psw_wr_en
      && !reg_wr |=> !trace_req && !psw[8])
      else $error("trace not cleared on entry");
   chk_zero_sign: assert property (clk_en && alu_req.en && alu_req.fmask == 16'hffff
      && !psw_wr_en && !reg_wr |=> psw[6] == (alu_result == 16'h0000)
      && psw[7] == ($past(alu_req.word) ? alu_result[15] : alu_result[7]))
      else $error("zero or sign flag wrong");
   chk_parity_even: assert property (clk_en && alu_req.en && alu_req.fmask == 16'hffff
      && !psw_wr_en && !reg_wr |=> psw[2] == ~^alu_result[7:0])
      else $error("parity flag wrong");
endmodule
bind cpu_regset cpu_regset_chk i_cpu_regset_chk (.core_clk(core_clk), .nrst(nrst),
   .clk_en(clk_en), .reg_wr(reg_wr), .psw_wr_en(psw_wr_en), .psw(psw), .irq_req(irq_req),
   .irq_take(irq_take), .instr_done(instr_done), .int_entry(int_entry),
   .trace_req(trace_req), .io_req(io_req), .io_addr(io_addr), .io_addr_valid(io_addr_valid),
   .agen_req(agen_req), .mem_addr_valid(mem_addr_valid), .alu_req(alu_req),
   .alu_result(alu_result));

// File: test/mem_io_partner.sv
// Far-side memory and port bus model that latches issued addresses
`timescale 1ns/10ps
module mem_io_partner (
   input wire logic core_clk,
   input wire logic [19:0] mem_addr,
   input wire logic mem_addr_valid,
   input wire logic [15:0] io_addr,
   input wire logic io_addr_valid,
   output logic [19:0] last_mem,
   output logic [15:0] last_io,
   output logic [7:0] reserved_hits
);
   initial begin
      last_mem = 20'h00000;
      last_io = 16'h0000;
      reserved_hits = 8'h00;
   end
   always @(posedge core_clk) begin
      if (mem_addr_valid) last_mem <= mem_addr;
      if (io_addr_valid) last_io <= io_addr;
      // No peripheral lives in the reserved ports; hits are only counted
      if (io_addr_valid && io_addr[15:3] == 13'h001f) reserved_hits <= reserved_hits + 8'h01;
   end
endmodule
